/* hdl/xbmc_regs.vh */
// Constants of the external bus mode controller: reset values, windows, field positions.
// Assumes inclusion by bare name from each design file.
`ifndef XBMC_REGS_VH
`define XBMC_REGS_VH

// Flag word layout
`define XBMC_FLAG_Z            0
`define XBMC_FLAG_C            1
`define XBMC_FLAG_V            2
`define XBMC_FLAG_N            3
`define XBMC_FLAG_D            4
`define XBMC_FLAG_U            5
`define XBMC_FLAG_I0           6
`define XBMC_FLAG_I1           7
`define XBMC_FLAGS_RESET       8'hC0

// Bank and page register reset values
`define XBMC_NEXT_BANK_RESET   8'h01
`define XBMC_PAGE_RESET        8'h00
`define XBMC_RESET_VEC_BANK    8'h00
`define XBMC_RESET_VEC_ADDR    16'h0000

// Mode bit values
`define XBMC_BUS_SINGLE        1'b0
`define XBMC_BUS_EXPAND        1'b1
`define XBMC_SPAN_MIN          1'b0
`define XBMC_SPAN_MAX          1'b1

// Address windows (24-bit logical space)
`define XBMC_CS0_INT_LO        24'h400000
`define XBMC_CS0_INT_HI        24'h4FFFFF
`define XBMC_CS1_LO            24'h100000
`define XBMC_CS1_HI            24'h1FFFFF
`define XBMC_CS2_LO            24'h200000
`define XBMC_CS2_HI            24'h2FFFFF
`define XBMC_CS3_LO            24'h300000
`define XBMC_CS3_HI            24'h3FFFFF
`define XBMC_CS0_EXT_LO        24'h000000
`define XBMC_CS0_EXT_HI        24'h0FFFFF
`define XBMC_INT_HOLE_LO       24'h00C000
`define XBMC_INT_HOLE_HI       24'h00FFFF

`endif

/* hdl/xbmc_decode.v */
// Address window decoder of the external bus mode controller.
// Assumes a registered access request; combinational result is registered by the caller.
`timescale 1ns/100ps

module xbmc_decode #(
  parameter NCS = 4
) (
  // Access
  input  wire [23:0]    addr,
  input  wire           ext_rom,
  // Result
  output reg  [NCS-1:0] cs_hit,
  output reg            ext_hit
);

`include "xbmc_regs.vh"

  always @* begin
    cs_hit = {NCS{1'b0}};
    if (ext_rom) begin
      // The internal RAM/IO hole never goes outside
      if (!(addr >= `XBMC_INT_HOLE_LO && addr <= `XBMC_INT_HOLE_HI))
        cs_hit[0] = (addr <= `XBMC_CS0_EXT_HI);
    end else begin
      cs_hit[0] = (addr >= `XBMC_CS0_INT_LO) && (addr <= `XBMC_CS0_INT_HI);
    end
    cs_hit[1] = (addr >= `XBMC_CS1_LO) && (addr <= `XBMC_CS1_HI);
    cs_hit[2] = (addr >= `XBMC_CS2_LO) && (addr <= `XBMC_CS2_HI);
    cs_hit[3] = (addr >= `XBMC_CS3_LO) && (addr <= `XBMC_CS3_HI);
    ext_hit = |cs_hit;
  end

endmodule

/* hdl/xbmc_ctrl.v */
// External bus mode controller: bus/CPU mode, pin sharing, chip selects, reset register values.
// Assumes one clock, a CPU core that presents one access per request, synchronous pins.
//
// Behaviour
// - Reset clears arithmetic flags, sets both interrupt mask flags.
// - Reset loads next code bank register with 01H.
// - Reset clears expand page and both index page registers.
// - Reset exception loads PC from bank 0 vector and code bank from next bank.
// - Twenty address lines share three output port groups, chosen by bus mode.
// - Port data and high-impedance registers stay storage while pins carry address.
// - Data bus shares the I/O group; port registers then act as storage.
// - Read and write strobes appear only on external accesses.
// - Software picks chip select or port per pin, except in single chip mode.
// - A chip select is asserted only for its own external window.
// - Bus expansion select 0 means single chip, 1 means expansion.
// - Single chip mode returns all shared pins to port functions.
// - External ROM strap forces expansion mode regardless of the select bit.
// - Internal ROM expansion maps external devices to 100000H-4FFFFFH only.
// - External ROM expansion maps 000000H-3FFFFFH, except internal 00C000H-00FFFFH.
// - Program span select 0 means minimum, 1 means maximum.
// - Minimum span keeps fetches in one bank; no code bank push on calls.
// - Maximum span allows multiple banks; code bank pushed on each call.
// - Internal ROM reset: single chip, minimum span, run internal ROM.
// - External ROM reset: expansion, minimum span, internal ROM off.
// - Internal ROM chip select windows: 4xxxxx, 1xxxxx, 2xxxxx, 3xxxxx for 0..3.
// - Select-capable pins reset to port; enable bit 1 turns chip select on.
// - External ROM strap always makes the first select pin chip select 0.
// - Halt or sleep holds all chip selects inactive.
`timescale 1ns/100ps

module xbmc_ctrl #(
  parameter NCS = 4
) (
  // Clock and reset
  input  wire        clk,
  input  wire        resetn,
  // Configuration
  input  wire        ext_rom_strap,
  input  wire        bus_expansion_select,
  input  wire        program_span_select,
  input  wire [3:0]  cs_enable,
  input  wire        standby,
  // CPU access request
  input  wire        acc_req,
  input  wire        acc_wr,
  input  wire [23:0] acc_addr,
  input  wire [7:0]  acc_wdata,
  input  wire        call_event,
  input  wire        reset_vec_valid,
  input  wire [15:0] reset_vec,
  input  wire        cb_load,
  input  wire [7:0]  cb_wdata,
  input  wire        nb_load,
  input  wire [7:0]  nb_wdata,
  // Port registers (general-purpose storage when the pin is a bus line)
  input  wire [7:0]  low_address_port_group,
  input  wire [7:0]  mid_address_port_group,
  input  wire [3:0]  high_address_port_group,
  input  wire        read_strobe_port,
  input  wire        write_strobe_port,
  input  wire [3:0]  select_capable_outputs,
  input  wire [7:0]  data_capable_io_group,
  input  wire [7:0]  data_io_dir,
  input  wire [7:0]  data_pin_in,
  // Pins
  output reg  [19:0] addr_pin_q,
  output reg  [7:0]  data_pin_out_q,
  output reg  [7:0]  data_pin_oe_q,
  output reg         rd_pin_n_q,
  output reg         wr_pin_n_q,
  output reg  [3:0]  select_pin_q,
  // CPU side results
  output reg  [7:0]  rdata_q,
  output reg         ext_access_q,
  output reg         expansion_q,
  output reg         span_max_q,
  output reg         int_rom_en_q,
  output reg         push_cb_q,
  output reg  [15:0] pc_q,
  output reg  [7:0]  code_bank_register_q,
  output reg  [7:0]  next_code_bank_register_q,
  output reg  [7:0]  expand_page_register_q,
  output reg  [7:0]  first_index_page_register_q,
  output reg  [7:0]  second_index_page_register_q,
  output reg  [7:0]  flags_q
);

`include "xbmc_regs.vh"

  ////////////////////////////////////////////////////////////////////////////
  // Strap capture

  reg        strap_q;
  reg        strap_done_q;

  // Caught on the first clock after release, then frozen
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      strap_q      <= 1'b0;
      strap_done_q <= 1'b0;
    end else if (!strap_done_q) begin
      strap_q      <= ext_rom_strap;
      strap_done_q <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Modes

  wire       expand_d;
  wire       span_d;

  // Software bits take effect only after the strap is known, so the reset modes hold
  assign expand_d = strap_done_q &&
                    (strap_q || (bus_expansion_select == `XBMC_BUS_EXPAND));
  assign span_d   = strap_done_q && (program_span_select == `XBMC_SPAN_MAX);

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      expansion_q  <= `XBMC_BUS_SINGLE;
      span_max_q   <= `XBMC_SPAN_MIN;
      int_rom_en_q <= 1'b1;
    end else begin
      expansion_q  <= strap_done_q ? expand_d : ext_rom_strap;
      span_max_q   <= span_d;
      int_rom_en_q <= strap_done_q ? !strap_q : !ext_rom_strap;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // CPU register reset values and bank control

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      flags_q                      <= `XBMC_FLAGS_RESET;
      next_code_bank_register_q    <= `XBMC_NEXT_BANK_RESET;
      code_bank_register_q         <= `XBMC_RESET_VEC_BANK;
      expand_page_register_q       <= `XBMC_PAGE_RESET;
      first_index_page_register_q  <= `XBMC_PAGE_RESET;
      second_index_page_register_q <= `XBMC_PAGE_RESET;
      pc_q                         <= `XBMC_RESET_VEC_ADDR;
      push_cb_q                    <= 1'b0;
    end else begin
      if (reset_vec_valid) begin
        pc_q                 <= reset_vec;
        code_bank_register_q <= next_code_bank_register_q;
      end else if (cb_load && span_max_q) begin
        // Bank fixed after initialisation in minimum span
        code_bank_register_q <= cb_wdata;
      end
      if (nb_load)
        next_code_bank_register_q <= nb_wdata;
      push_cb_q <= call_event && span_max_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Address decode

  wire [NCS-1:0] cs_hit;
  wire           ext_hit;

  xbmc_decode #(
    .NCS (NCS)
  ) u_decode (
    .addr    (acc_addr),
    .ext_rom (strap_q),
    .cs_hit  (cs_hit),
    .ext_hit (ext_hit)
  );

  wire           ext_go;
  wire [NCS-1:0] cs_func;

  // Internal accesses and standby drive the address pins but never a strobe or select
  assign ext_go = acc_req && expansion_q && ext_hit && !standby;

  genvar gi;
  generate
    for (gi = 0; gi < NCS; gi = gi + 1) begin : g_sel
      if (gi == 0) begin : g_first
        assign cs_func[gi] = expansion_q && (cs_enable[gi] || strap_q);
      end else begin : g_rest
        assign cs_func[gi] = expansion_q && cs_enable[gi];
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Pin multiplexing

  integer i;
  reg     rd_pend_q;

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rd_pend_q      <= 1'b0;
      addr_pin_q     <= 20'h00000;
      data_pin_out_q <= 8'h00;
      data_pin_oe_q  <= 8'h00;
      rd_pin_n_q     <= 1'b1;
      wr_pin_n_q     <= 1'b1;
      select_pin_q   <= 4'hF;
      rdata_q        <= 8'h00;
      ext_access_q   <= 1'b0;
    end else begin
      ext_access_q <= ext_go;
      rd_pend_q    <= ext_go && !acc_wr;
      if (expansion_q) begin
        // Port registers are untouched here; they stay plain storage
        addr_pin_q     <= acc_addr[19:0];
        data_pin_out_q <= acc_wdata;
        data_pin_oe_q  <= {8{ext_go && acc_wr}};
        rd_pin_n_q     <= !(ext_go && !acc_wr);
        wr_pin_n_q     <= !(ext_go && acc_wr);
      end else begin
        addr_pin_q     <= {high_address_port_group, mid_address_port_group,
                           low_address_port_group};
        data_pin_out_q <= data_capable_io_group;
        data_pin_oe_q  <= data_io_dir;
        rd_pin_n_q     <= read_strobe_port;
        wr_pin_n_q     <= write_strobe_port;
      end
      for (i = 0; i < NCS; i = i + 1) begin
        if (cs_func[i])
          select_pin_q[i] <= !(ext_go && cs_hit[i]);
        else
          select_pin_q[i] <= select_capable_outputs[i];
      end
      // Data is only valid while the read strobe is low at the pins, one edge later
      if (rd_pend_q)
        rdata_q <= data_pin_in;
    end
  end

endmodule

/* test/xbmc_ext_mem.sv */
// External memory on the shared bus, one byte per low address byte.
// Assumes registered active-low strobes and bus pins on clk.
`timescale 1ns/100ps
module xbmc_ext_mem (
  input logic        clk,
  input logic        rd_n,
  input logic        wr_n,
  input logic [19:0] addr,
  input logic [7:0]  dout,
  output logic [7:0] din
);
  logic [7:0] mem [0:255];
  logic [7:0] last_q = 8'h00;
  initial for (int i = 0; i < 256; i++) mem[i] = i[7:0];
  // A released bus shows the inverse of the last byte, never a stale copy
  assign din = rd_n ? ~last_q : mem[addr[7:0]];
  always @(posedge clk) begin
    if (!rd_n) last_q <= mem[addr[7:0]];
    if (!wr_n) mem[addr[7:0]] <= dout;
  end
endmodule

/* test/xbmc_ctrl_checker.sv */
// Pin checks of the bus mode controller against its access requests.
// Assumes it is bound into xbmc_ctrl and sees only its ports.
`timescale 1ns/100ps
module xbmc_checker (
  input logic        clk, resetn, standby, acc_req, acc_wr, call_event,
  input logic [3:0]  cs_enable, high_address_port_group, select_pin_q,
  input logic [23:0] acc_addr,
  input logic [7:0]  acc_wdata, low_address_port_group, mid_address_port_group,
  input logic [7:0]  data_pin_out_q, data_pin_oe_q,
  input logic [19:0] addr_pin_q,
  input logic        rd_pin_n_q, wr_pin_n_q, ext_access_q, expansion_q,
  input logic        span_max_q, int_rom_en_q, push_cb_q
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  sequence req_s; acc_req && expansion_q && !standby; endsequence
  sequence mcu_s; req_s ##0 int_rom_en_q; endsequence
  ////////////////////////////////////////////////////////////////////////////////
  rd_ext_a: assert property (
    mcu_s ##0 (!acc_wr && acc_addr[23:20] == 4'h4) |=> !rd_pin_n_q && wr_pin_n_q && ext_access_q)
    else $error("read strobe missing");
  wr_ext_a: assert property (
    mcu_s ##0 (acc_wr && acc_addr[23:20] == 4'h2) |=> !wr_pin_n_q && rd_pin_n_q &&
    data_pin_oe_q == 8'hFF && data_pin_out_q == $past(acc_wdata))
    else $error("write cycle wrong");
  cs1_win_a: assert property (
    req_s ##0 (cs_enable[1] && acc_addr[23:20] == 4'h1) |=>
    !select_pin_q[1] && addr_pin_q == $past(acc_addr[19:0]))
    else $error("select 1 missing");
  stby_quiet_a: assert property (acc_req && standby |=> !ext_access_q)
    else $error("access during standby");
  hole_int_a: assert property (
    !int_rom_en_q && acc_addr[23:14] == 10'h003 |=> !ext_access_q && rd_pin_n_q && wr_pin_n_q)
    else $error("internal hole went out");
  low_int_a: assert property (int_rom_en_q && acc_addr < 24'h100000 |=> !ext_access_q)
    else $error("internal area went out");
  single_pins_a: assert property (
    !expansion_q && !$rose(resetn) |=> !ext_access_q && addr_pin_q ==
    $past({high_address_port_group, mid_address_port_group, low_address_port_group}))
    else $error("single chip pins wrong");
  push_cb_a: assert property (call_event |=> push_cb_q == $past(span_max_q))
    else $error("bank push wrong");
  ext_mode_a: assert property (!int_rom_en_q |-> expansion_q)
    else $error("single chip with ext rom");
endmodule
bind xbmc_ctrl xbmc_checker u_checker (.*);

/* test/test_external_bus_mode_control.sv */
// Bench of the bus mode controller with an external memory model.
// Assumes design, checker and memory model compiled before it.
`timescale 1ns/100ps
module test_external_bus_mode_control;
  logic clk, resetn, ext_rom_strap, bus_expansion_select, program_span_select, standby;
  logic acc_req, acc_wr, call_event, reset_vec_valid, cb_load, nb_load, strap_m;
  logic read_strobe_port, write_strobe_port, rd_pin_n_q, wr_pin_n_q, ext_access_q;
  logic expansion_q, span_max_q, int_rom_en_q, push_cb_q;
  logic [3:0] cs_enable, high_address_port_group, select_capable_outputs, select_pin_q;
  logic [7:0] acc_wdata, cb_wdata, nb_wdata, low_address_port_group, mid_address_port_group;
  logic [7:0] data_capable_io_group, data_io_dir, data_pin_in, data_pin_out_q, data_pin_oe_q;
  logic [7:0] rdata_q, code_bank_register_q, next_code_bank_register_q, flags_q;
  logic [7:0] expand_page_register_q, first_index_page_register_q, second_index_page_register_q;
  logic [15:0] reset_vec, pc_q;
  logic [19:0] addr_pin_q;
  logic [23:0] acc_addr;
  logic [31:0] lfsr = 32'h4C42;
  logic [7:0] bmem [int];
  logic [23:0] tbl [12] = '{24'h000000, 24'h00BFFF, 24'h00C000, 24'h00FFFF, 24'h010000,
    24'h100000, 24'h1FFFFF, 24'h2ABCDE, 24'h3FFFFF, 24'h400000, 24'h4FFFFF, 24'h500000};
  int n_errors = 0, comparisons = 0, cyc = 0;

  xbmc_ctrl dut (.*);
  xbmc_ext_mem u_mem (.clk, .rd_n(rd_pin_n_q), .wr_n(wr_pin_n_q), .addr(addr_pin_q),
    .dout(data_pin_out_q), .din(data_pin_in));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc > 5000) begin
      n_errors++;
      summarize();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(string nm, logic [23:0] seen, logic [23:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic summarize();
    if (n_errors == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    {high_address_port_group, mid_address_port_group, low_address_port_group} = lfsr[19:0];
    {select_capable_outputs, read_strobe_port, write_strobe_port} = lfsr[29:24];
    {data_capable_io_group, data_io_dir} = lfsr[31:16];
  endtask
  task automatic do_reset(logic strap);
    resetn = 1'b0;
    ext_rom_strap = strap;
    strap_m = strap;
    // Port write bit high, so the port-mode cycle after release writes no memory
    write_strobe_port = 1'b1;
    repeat (2) @(posedge clk);
    #1 resetn = 1'b1;
    @(posedge clk);
    #1 ext_rom_strap = ~strap;
  endtask
  // Model of the decode: -1 for no external access, else the select number
  function automatic int cs_of(logic [23:0] a);
    if (!(bus_expansion_select || strap_m) || standby) return -1;
    if (strap_m) return (a > 24'h3FFFFF || a[23:14] == 10'h003) ? -1 : int'(a[21:20]);
    return (a < 24'h100000 || a > 24'h4FFFFF) ? -1 : (a[22] ? 0 : int'(a[21:20]));
  endfunction
  task automatic acc(logic wr, logic [23:0] a);
    int c;
    logic exm;
    logic [7:0] d;
    rnd();
    c = cs_of(a);
    exm = bus_expansion_select || strap_m;
    d = lfsr[15:8];
    {acc_req, acc_wr, acc_addr, acc_wdata} = {1'b1, wr, a, d};
    @(posedge clk);
    #1 acc_req = 1'b0;
    chk("ext", ext_access_q, c >= 0);
    chk("addr", addr_pin_q, exm ? a[19:0] : lfsr[19:0]);
    chk("rd", rd_pin_n_q, exm ? !(c >= 0 && !wr) : read_strobe_port);
    chk("wr", wr_pin_n_q, exm ? !(c >= 0 && wr) : write_strobe_port);
    for (int i = 0; i < 4; i++)
      chk("sel", select_pin_q[i], (exm && (cs_enable[i] || (i == 0 && strap_m))) ?
        c != i : select_capable_outputs[i]);
    chk("oe", data_pin_oe_q, exm ? {8{c >= 0 && wr}} : data_io_dir);
    chk("dout", data_pin_out_q, exm ? d : data_capable_io_group);
    if (c >= 0 && wr) bmem[a[7:0]] = d;
    // In single chip the port write bit reaches the memory strobe too
    if (!exm && !write_strobe_port) bmem[low_address_port_group] = data_capable_io_group;
    @(posedge clk);
    #1;
    if (c >= 0 && !wr) chk("rdata", rdata_q, bmem.exists(a[7:0]) ? bmem[a[7:0]] : a[7:0]);
  endtask
  task automatic sweep(logic [3:0] mask);
    for (int i = 0; i < 52; i++) begin
      cs_enable = lfsr[3:0] & mask;
      if (i < 24) acc(~i[0], tbl[i / 2]);
      else acc(lfsr[31], {1'b0, lfsr[22:0]});
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {standby, acc_req, acc_wr, call_event, reset_vec_valid, cb_load, nb_load} = '0;
    {bus_expansion_select, program_span_select, cs_enable, acc_addr, acc_wdata} = '0;
    {cb_wdata, nb_wdata, reset_vec} = '0;
    rnd();
    do_reset(1'b0);
    chk("flags", flags_q, 8'hC0);
    chk("nbank", next_code_bank_register_q, 8'h01);
    chk("pages", {expand_page_register_q, first_index_page_register_q,
      second_index_page_register_q}, 24'h0);
    chk("mode", {expansion_q, span_max_q, int_rom_en_q}, 3'b001);
    {reset_vec, reset_vec_valid} = {16'h5A3C, 1'b1};
    @(posedge clk);
    #1 reset_vec_valid = 1'b0;
    chk("pc", pc_q, 16'h5A3C);
    chk("cbank", code_bank_register_q, 8'h01);
    sweep(4'hF);
    bus_expansion_select = 1'b1;
    repeat (2) @(posedge clk);
    #1 chk("mode", expansion_q, 1'b1);
    sweep(4'hF);
    standby = 1'b1;
    acc(1'b0, 24'h100000);
    standby = 1'b0;
    for (int s = 0; s < 2; s++) begin
      program_span_select = s[0];
      repeat (2) @(posedge clk);
      #1 call_event = 1'b1;
      @(posedge clk);
      #1 call_event = 1'b0;
      chk("push", push_cb_q, s[0]);
    end
    {bus_expansion_select, program_span_select} = 2'b00;
    do_reset(1'b1);
    chk("mode", {expansion_q, span_max_q, int_rom_en_q}, 3'b100);
    sweep(4'h0);
    summarize();
  end
endmodule
